// >>> dco_pkg.sv
// Package for the differential clock output control block.
// Assumes a single 200 MHz system clock and an Avalon-MM register master.
// Notes on behaviour
// - Power-down accepted after two stable complement edges
// - Stop accepted after two stable complement edges
// - Power-down floats both complement and true
// - Stop floats complement, drives true at 6x
// - Polarity strap inverts power-down and stop sense
// - Stop acts only on pairs whose stop-response bit is set
// - Enable changes take effect within 2-6 periods
// - Pins driven within 300 us of wake
// - Valid toggling within 1 ms of wake
// - Per-pair stop-response bit, default free running
package dco_pkg;
	localparam int NUM_PAIRS = 8;
	// Register byte offsets
	localparam logic [3:0] REG_OE_OFS = 4'h0;
	localparam logic [3:0] REG_STOPCFG_OFS = 4'h4;
	localparam logic [3:0] REG_STATUS_OFS = 4'h8;
	// Values after reset
	localparam logic [7:0] OE_RESET = 8'hff;
	localparam logic [7:0] STOPCFG_RESET = 8'h00;
	// Status field positions
	localparam int ST_PD_BIT = 8;
	localparam int ST_STOP_BIT = 9;
	localparam int ST_STATE_LSB = 10;
	localparam int ST_POL_BIT = 12;
	// Debounced vector layout: [7:0] enables, then power-down, stop
	localparam int REC_PD = 8;
	localparam int REC_STOP = 9;
	// Timing
	localparam int CLOCK_MHZ = 200;
	localparam int WAKE_DRIVE_US = 300;
	localparam int WAKE_TOGGLE_MS = 1;
	localparam int WAKE_DRIVE_CYC = WAKE_DRIVE_US * CLOCK_MHZ;
	localparam int WAKE_TOGGLE_CYC = WAKE_TOGGLE_MS * 1000 * CLOCK_MHZ;
	localparam int WAKE_CNT_W = 18;
	typedef enum logic [1:0]
	{
		ST_RUN = 2'b00,
		ST_SLEEP = 2'b01,
		ST_WAKE = 2'b10,
		ST_DRIVE = 2'b11
	} dco_state_t;
endpackage

// >>> dco_output_control.sv
// Output control for an eight-pair differential clock fan-out.
// Assumes pins are asynchronous and the reference clock is well below half the system clock.
//
// Added by the designer: the Avalon-MM slave port and the register addresses.
`timescale 1ns/1ps
module dco_output_control
	import dco_pkg::*;
#(
	parameter int unsigned P_DRIVE_CYC = WAKE_DRIVE_CYC,
	parameter int unsigned P_TOGGLE_CYC = WAKE_TOGGLE_CYC
)
(
	input wire logic i_clock,
	input wire logic i_rst_n,
	input wire logic i_reference_clock_input,
	input wire logic i_power_down,
	input wire logic i_output_stop_input,
	input wire logic i_control_polarity_select,
	input wire logic [7:0] i_output_enable,
	input wire logic [3:0] i_avs_address,
	input wire logic i_avs_read,
	input wire logic i_avs_write,
	input wire logic [31:0] i_avs_writedata,
	input wire logic [3:0] i_avs_byteenable,
	output logic [31:0] o_avs_readdata,
	output logic o_avs_waitrequest,
	output logic [7:0] o_clock_out_true,
	output logic [7:0] o_clock_out_true_oe_n,
	output logic [7:0] o_clock_out_complement,
	output logic [7:0] o_clock_out_complement_oe_n,
	output logic [7:0] o_park_x6
);
	logic [11:0] sync_a;
	logic [11:0] sync_b;
	logic pol;
	logic ref_d;
	logic [9:0] s1;
	logic [9:0] s2;
	logic [9:0] rec;
	dco_state_t st;
	dco_state_t next_st;
	logic [WAKE_CNT_W-1:0] wcnt;
	logic [7:0] run_q;
	logic [7:0] park_q;
	logic [7:0] hold_q;
	logic [7:0] oe_reg;
	logic [7:0] stop_cfg;
	logic ack;

	// Pin synchronisers; first stage feeds only the second
	always_ff @(posedge i_clock)
	begin
		sync_a <= {i_control_polarity_select, i_output_enable, i_output_stop_input,
			i_power_down, i_reference_clock_input};
		sync_b <= sync_a;
	end

	wire ref_s = sync_b[0];
	wire pd_pin = sync_b[1];
	wire stop_pin = sync_b[2];
	wire [7:0] oe_pin = sync_b[10:3];
	wire pol_pin = sync_b[11];
	// Complement rising edge is the true falling edge: the cycle boundary
	wire bnd = ref_d & ~ref_s;

	// Strap is caught while reset is held, then frozen
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
			pol <= pol_pin;
	end

	wire pd_act = pol ? pd_pin : ~pd_pin;
	wire stop_act = pol ? stop_pin : ~stop_pin;
	wire [7:0] oe_act = pol ? ~oe_pin : oe_pin;
	wire [9:0] samp = {stop_act, pd_act, oe_act};

	wire [9:0] next_rec = (s1 & s2) | (rec & (s1 | s2));

	// Sample controls on each boundary; a level is taken once two samples agree
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			ref_d <= 1'b0;
			s1 <= 10'h000;
			s2 <= 10'h000;
			rec <= 10'h000;
		end
		else
		begin
			ref_d <= ref_s;
			if (bnd)
			begin
				s1 <= samp;
				s2 <= s1;
				rec <= next_rec;
			end
		end
	end

	wire pd_on = rec[REC_PD];
	wire stop_on = rec[REC_STOP];
	// debounced pin enables gated by the mask
	wire [7:0] en = rec[7:0] & oe_reg;
	wire drive_due = wcnt == WAKE_CNT_W'(P_DRIVE_CYC - 1);
	wire toggle_due = wcnt == WAKE_CNT_W'(P_TOGGLE_CYC - 1);

	// Power state: sleep, count toward drive, then toward toggling
	always_comb
	begin
		next_st = st;
		unique case (st)
			ST_RUN: if (pd_on) next_st = ST_SLEEP;
			ST_SLEEP: if (!pd_on) next_st = ST_WAKE;
			ST_WAKE:
			begin
				if (pd_on)
					next_st = ST_SLEEP;
				else if (drive_due)
					next_st = ST_DRIVE;
			end
			ST_DRIVE:
			begin
				if (pd_on)
					next_st = ST_SLEEP;
				else if (toggle_due)
					next_st = ST_RUN;
			end
		endcase
	end

	// Wake counter runs from power-down release until toggling starts
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			st <= ST_RUN;
			wcnt <= '0;
		end
		else
		begin
			st <= next_st;
			wcnt <= (st == ST_WAKE || st == ST_DRIVE) ? wcnt + 1'b1 : '0;
		end
	end

	wire [7:0] stopped = stop_on ? stop_cfg : 8'h00;
	wire is_run = st == ST_RUN;
	wire [7:0] next_run = is_run ? en & ~stopped : 8'h00;
	wire [7:0] next_park = is_run ? en & stopped : 8'h00;
	// only DRIVE holds pins static; sleep floats all
	wire [7:0] next_hold = (st == ST_DRIVE) ? en : 8'h00;

	// pair modes update at boundaries only, while the true phase is low
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			run_q <= 8'h00;
			park_q <= 8'h00;
			hold_q <= 8'h00;
		end
		else if (bnd)
		begin
			run_q <= next_run;
			park_q <= next_park;
			hold_q <= next_hold;
		end
	end

	// pins take the new mode on the boundary edge itself, so the complement
	// half that starts there is never cut into a runt
	wire [7:0] run_now = bnd ? next_run : run_q;
	wire [7:0] park_now = bnd ? next_park : park_q;
	wire [7:0] hold_now = bnd ? next_hold : hold_q;

	// Registered pins; a one-cycle lag keeps them free of decode glitches
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			o_clock_out_true <= 8'h00;
			o_clock_out_true_oe_n <= 8'hff;
			o_clock_out_complement <= 8'h00;
			o_clock_out_complement_oe_n <= 8'hff;
			o_park_x6 <= 8'h00;
		end
		else
		begin
			o_clock_out_true <= (run_now & {8{ref_s}}) | park_now;
			o_clock_out_true_oe_n <= ~(run_now | park_now | hold_now);
			o_clock_out_complement <= (run_now & {8{~ref_s}}) | hold_now;
			o_clock_out_complement_oe_n <= ~(run_now | hold_now);
			o_park_x6 <= park_now;
		end
	end

	// Avalon slave: one wait cycle, answer at the second edge
	wire req = i_avs_read | i_avs_write;
	wire wr_go = i_avs_write & ack & i_avs_byteenable[0];
	wire [31:0] status = {19'h0_0000, pol, st, stop_on, pd_on, run_q};
	wire [31:0] rd_mux = (i_avs_address == REG_OE_OFS) ? {24'h00_0000, oe_reg} :
		(i_avs_address == REG_STOPCFG_OFS) ? {24'h00_0000, stop_cfg} :
		(i_avs_address == REG_STATUS_OFS) ? status : 32'h0000_0000;
	assign o_avs_waitrequest = req & ~ack;

	// Registers and handshake; unmapped writes are dropped
	always_ff @(posedge i_clock)
	begin
		if (!i_rst_n)
		begin
			ack <= 1'b0;
			oe_reg <= OE_RESET;
			stop_cfg <= STOPCFG_RESET;
			o_avs_readdata <= 32'h0000_0000;
		end
		else
		begin
			ack <= req & ~ack;
			if (i_avs_read & ~ack)
				o_avs_readdata <= rd_mux;
			if (wr_go && i_avs_address == REG_OE_OFS)
				oe_reg <= i_avs_writedata[7:0];
			if (wr_go && i_avs_address == REG_STOPCFG_OFS)
				stop_cfg <= i_avs_writedata[7:0];
		end
	end

	// Checks
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rst_n);

	AST_PD_DEBOUNCE: assert property ($changed(rec[REC_PD]) |->
		$past(s1[REC_PD]) == $past(s2[REC_PD]) && rec[REC_PD] == $past(s1[REC_PD]))
		else $error("power-down taken without two stable samples");
	AST_STOP_DEBOUNCE: assert property ($changed(rec[REC_STOP]) |->
		$past(s1[REC_STOP]) == $past(s2[REC_STOP]) && $past(bnd))
		else $error("stop taken without two stable samples");
	AST_PD_FLOAT: assert property ((st == ST_SLEEP && bnd) |=>
		(run_q == 8'h00 && hold_q == 8'h00) ##1 (&o_clock_out_true_oe_n && &o_clock_out_complement_oe_n))
		else $error("pins not floated in power-down");
	AST_STOP_PARK: assert property ((is_run && bnd && stop_on) |=>
		park_q == $past(en & stop_cfg) ##1 (o_park_x6 & o_clock_out_complement_oe_n) == park_q)
		else $error("stopped pair not parked");
	AST_STOP_ALL: assert property ((is_run && bnd && stop_on && stop_cfg == 8'hff) |=>
		run_q == 8'h00)
		else $error("a pair kept running under stop");
	AST_BOUNDARY: assert property ($changed(run_q) || $changed(park_q) |-> $past(bnd))
		else $error("pair mode changed off a boundary");
	AST_WAKE_DRIVE: assert property (st == ST_WAKE |-> wcnt < WAKE_CNT_W'(P_DRIVE_CYC))
		else $error("drive deadline missed");
	AST_WAKE_TOGGLE: assert property (st == ST_DRIVE |-> wcnt < WAKE_CNT_W'(P_TOGGLE_CYC))
		else $error("toggle deadline missed");
	AST_CFG_RESET: assert property ($rose(i_rst_n) |-> stop_cfg == 8'h00)
		else $error("stop response not reset to free running");

	COV_WAKE: cover property (st == ST_DRIVE ##1 st == ST_RUN);
	COV_PARK: cover property (stop_on && |park_q);
	COV_OE_WRITE: cover property (wr_go && i_avs_address == REG_OE_OFS);
endmodule

// >>> dco_platform_model.sv
// Platform model: makes the reference clock and drives the control pins.
// Assumes the bench calls set_pins; pins move off the system clock grid.
`timescale 1ns/1ps
module dco_platform_model
(
	output logic o_ref,
	output logic o_pd,
	output logic o_stop,
	output logic [7:0] o_oe
);
	// Reference of 80 ns stays well below the sampling limit
	initial
	begin
		o_ref = 1'b0;
		forever #40 o_ref = ~o_ref;
	end
	// Start with power-down and stop inactive and all enables on for the low strap
	initial
	begin
		o_pd = 1'b1;
		o_stop = 1'b1;
		o_oe = 8'hff;
	end
	task set_pins(input logic pd, input logic stop, input logic [7:0] oe);
		#1.3;
		o_pd = pd;
		o_stop = stop;
		o_oe = oe;
	endtask
endmodule

// >>> tb_top.sv
// Bench for the clock output control block.
// Assumes the platform model supplies an 80 ns reference and drives the pins.
`timescale 1ns/1ps
module tb_top;
	import dco_pkg::*;
	logic i_clock, i_rst_n, pol, rd, wr, wait_req, ref_clk, pd, stop;
	logic [3:0] adr;
	logic [31:0] wd, rdata, got;
	logic [7:0] oe, t, t_oe_n, c, c_oe_n, park;
	int error_cnt, check_count, cyc, n;
	dco_output_control #(.P_DRIVE_CYC(20), .P_TOGGLE_CYC(50)) i_dut (.i_clock(i_clock), .i_rst_n(i_rst_n),
		.i_reference_clock_input(ref_clk), .i_power_down(pd), .i_output_stop_input(stop),
		.i_control_polarity_select(pol), .i_output_enable(oe), .i_avs_address(adr), .i_avs_read(rd),
		.i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(4'h1), .o_avs_readdata(rdata),
		.o_avs_waitrequest(wait_req), .o_clock_out_true(t), .o_clock_out_true_oe_n(t_oe_n),
		.o_clock_out_complement(c), .o_clock_out_complement_oe_n(c_oe_n), .o_park_x6(park));
	dco_platform_model i_plat (.o_ref(ref_clk), .o_pd(pd), .o_stop(stop), .o_oe(oe));
	// System clock, 5 ns period
	initial
	begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	// Hang guard, far above the expected run length
	always @(posedge i_clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 20000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end
	task tally_and_finish;
		if (error_cnt == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	// One bus cycle; request held until waitrequest is low at a rising edge
	task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge i_clock);
		rd <= ~w;
		wr <= w;
		adr <= a;
		wd <= d;
		@(negedge i_clock);
		while (wait_req !== 1'b0)
		begin
			@(posedge i_clock);
			@(negedge i_clock);
		end
		@(posedge i_clock);
		got = rdata;
		rd <= 1'b0;
		wr <= 1'b0;
	endtask
	// Pin effects are timed in reference periods; pins are read mid-cycle, where settled
	task ref_wait(input int k);
		repeat (k) @(negedge ref_clk);
		@(negedge i_clock);
	endtask
	// Main sequence
	initial
	begin
		{i_rst_n, pol, rd, wr, adr, wd, error_cnt, check_count} = '0;
		repeat (10) @(posedge i_clock);
		i_rst_n <= 1'b1;
		bus(0, REG_OE_OFS, 0); chk(got, 32'h0000_00ff);
		bus(0, REG_STOPCFG_OFS, 0); chk(got, 32'h0000_0000);
		bus(0, 4'hc, 0); chk(got, 32'h0000_0000);
		ref_wait(6); chk({c_oe_n, t_oe_n, c ^ t}, 32'h0000_00ff);
		bus(1, REG_STOPCFG_OFS, 32'h0000_0081);
		i_plat.set_pins(1, 0, 8'hff);
		ref_wait(1); chk(park, 0);
		ref_wait(5); chk({park, c_oe_n, t_oe_n, t & 8'h81}, 32'h8181_0081);
		bus(1, REG_STOPCFG_OFS, 32'h0000_00ff);
		ref_wait(6); chk(park, 8'hff);
		i_plat.set_pins(1, 1, 8'hff);
		ref_wait(6); chk(park, 0);
		// Stop pulse of 60 ns spans exactly one boundary sample; nothing may park
		@(posedge ref_clk);
		@(posedge i_clock);
		i_plat.set_pins(1, 0, 8'hff);
		repeat (12) @(posedge i_clock);
		i_plat.set_pins(1, 1, 8'hff);
		n = 0;
		repeat (100)
		begin
			@(negedge i_clock);
			if (park !== 8'h00)
				n++;
		end
		chk(n, 0);
		bus(1, REG_OE_OFS, 32'h0000_007f);
		i_plat.set_pins(1, 1, 8'hfd);
		ref_wait(1); chk(t_oe_n & 8'h02, 0);
		ref_wait(5); chk({t_oe_n, c_oe_n}, 16'h8282);
		// Pair 1 back by pin, pair 7 by mask; the pin path may not act within one period
		bus(1, REG_OE_OFS, 32'h0000_00ff);
		i_plat.set_pins(1, 1, 8'hff);
		ref_wait(1); chk(c_oe_n & 8'h02, 8'h02);
		ref_wait(5); chk({c_oe_n, t_oe_n, c ^ t}, 32'h0000_00ff);
		i_plat.set_pins(0, 1, 8'hff);
		ref_wait(1); chk(c_oe_n, 0);
		ref_wait(5); chk({t_oe_n, c_oe_n}, 16'hffff);
		bus(0, REG_STATUS_OFS, 0); chk(32'(got[ST_PD_BIT]), 1);
		// Wake: count cycles to driven pins, then to toggling
		i_plat.set_pins(1, 1, 8'hff);
		n = 0;
		while (c_oe_n === 8'hff && n < 500)
		begin
			@(posedge i_clock);
			n++;
		end
		chk(32'(n <= 100), 1);
		while (t[0] !== 1'b1 && n < 500)
		begin
			@(posedge i_clock);
			n++;
		end
		chk(32'(n <= 150), 1);
		// Second reset with the strap high inverts the pin sense
		i_rst_n <= 1'b0;
		pol <= 1'b1;
		i_plat.set_pins(0, 0, 8'h00);
		repeat (10) @(posedge i_clock);
		i_rst_n <= 1'b1;
		ref_wait(6); chk({c_oe_n, t_oe_n}, 0);
		i_plat.set_pins(1, 0, 8'h00);
		ref_wait(6); chk(c_oe_n, 8'hff);
		tally_and_finish();
	end
endmodule
